// File: dv/interrupt_vector_map_asserts.sv
`timescale 1ns/1ps
module vector_map_checker #(
   parameter int NUM_EXT = 8,
   parameter int NUM_RELOAD = 3
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RST_B,
   input wire logic i_NMI,
   input wire logic [NUM_EXT-1:0] i_EXT_IRQ,
   input wire logic i_WAKEUP,
   input wire logic [4:0] i_DMA_END,
   input wire logic [4:0] i_DMA_ERR,
   input wire logic i_DMA_CNT_ACCESS,
   input wire logic [1:0] i_DMA_CNT_SIZE,
   input wire logic o_VEC_VALID,
   input wire logic [7:0] o_VEC_NUM,
   input wire logic [4:0] o_VEC_LEVEL,
   input wire logic [31:0] o_VEC_ADDR,
   input wire logic o_DMA_CNT_BYTE_ERR
);
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_RST_B);
   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   sequence release_s;
      $rose(I_RST_B);
   endsequence
   sequence byte_access_s;
      i_DMA_CNT_ACCESS && i_DMA_CNT_SIZE == 2'h0;
   endsequence
   // ----------------------------------------
   // Vector, address and byte-access checks
   // ----------------------------------------
   reset_vector_a: assert property (release_s |=> o_VEC_VALID && o_VEC_NUM == 8'h00)
      else $error("reset vector not shown after release");
   reserved_never_a: assert property (o_VEC_VALID |-> !(o_VEC_NUM inside {[8'h02:8'h06]}))
      else $error("reserved vector produced");
   nmi_level_a: assert property (o_VEC_VALID && o_VEC_NUM == 8'h0f |-> o_VEC_LEVEL == 5'h0f)
      else $error("nmi level not fixed");
   nmi_source_a: assert property (o_VEC_VALID && o_VEC_NUM == 8'h0f |-> $past(i_NMI))
      else $error("nmi vector without nmi");
   wake_bound_a: assert property (i_WAKEUP |=> o_VEC_VALID && o_VEC_NUM <= 8'h16)
      else $error("wake-up not vectored at shared slot");
   wake_source_a: assert property (o_VEC_VALID && o_VEC_NUM == 8'h16 |->
      $past(i_EXT_IRQ[6] || i_WAKEUP)) else $error("shared slot without cause");
   dma_source_a: assert property (o_VEC_VALID && o_VEC_NUM == 8'h20 |->
      $past((|i_DMA_END[4:2]) || (|i_DMA_ERR[4:2]))) else $error("dma group without cause");
   dma_pair_a: assert property (i_DMA_ERR[0] |=> o_VEC_VALID && o_VEC_NUM <= 8'h1e)
      else $error("dma error not vectored");
   addr_offset_a: assert property (o_VEC_VALID |->
      o_VEC_ADDR[9:0] == 10'h3fc - {o_VEC_NUM, 2'b00}) else $error("vector address offset");
   byte_guard_a: assert property (byte_access_s |=> o_DMA_CNT_BYTE_ERR)
      else $error("byte access not flagged");
   byte_clear_a: assert property (!(i_DMA_CNT_ACCESS && i_DMA_CNT_SIZE == 2'h0) |=>
      !o_DMA_CNT_BYTE_ERR) else $error("byte flag without byte access");
endmodule

bind interrupt_vector_map vector_map_checker #(.NUM_EXT(NUM_EXT), .NUM_RELOAD(NUM_RELOAD)) u_chk (
   .I_CLK_SYS(I_CLK_SYS), .I_RST_B(I_RST_B), .i_NMI(i_NMI), .i_EXT_IRQ(i_EXT_IRQ),
   .i_WAKEUP(i_WAKEUP), .i_DMA_END(i_DMA_END), .i_DMA_ERR(i_DMA_ERR),
   .i_DMA_CNT_ACCESS(i_DMA_CNT_ACCESS), .i_DMA_CNT_SIZE(i_DMA_CNT_SIZE),
   .o_VEC_VALID(o_VEC_VALID), .o_VEC_NUM(o_VEC_NUM), .o_VEC_LEVEL(o_VEC_LEVEL),
   .o_VEC_ADDR(o_VEC_ADDR), .o_DMA_CNT_BYTE_ERR(o_DMA_CNT_BYTE_ERR));

// File: dv/interrupt_vector_map_tb_top.sv
`timescale 1ns/1ps
module interrupt_vector_map_tb_top;
   logic I_CLK_SYS, I_RST_B, base_we, lvl_we, acc_go, cnt_acc, vec_valid, byte_err;
   logic [31:0] base, vec_addr;
   logic [34:0] req;
   logic [4:0] lvl_idx, lvl_wdata, lvl_ridx, lvl_rdata, vec_level;
   logic [1:0] acc_size, cnt_size;
   logic [7:0] vec_num;
   logic [4:0] lvl [17];
   logic [44:0] expq [$];
   int err_count, compares;
   interrupt_vector_map #(.NUM_EXT(8), .NUM_RELOAD(3)) dut (
      .I_CLK_SYS(I_CLK_SYS), .I_RST_B(I_RST_B), .i_TABLE_BASE(base), .i_TABLE_BASE_WE(base_we),
      .i_MODE_REQ(req[0]), .i_COPRO_ABSENT(req[1]), .i_COPRO_ERROR(req[2]), .i_EMU_TRAP(req[3]),
      .i_INSN_BREAK(req[4]), .i_OPND_BREAK(req[5]), .i_STEP_TRACE(req[6]), .i_TOOL_NMI(req[7]),
      .i_UNDEF_INSN(req[8]), .i_NMI(req[9]), .i_EXT_IRQ(req[17:10]), .i_WAKEUP(req[18]),
      .i_RELOAD_IRQ(req[21:19]), .i_SERIAL_RX(req[22]), .i_SERIAL_TX(req[23]),
      .i_DEAD_TIME_TRIP(req[24]), .i_DMA_END(req[29:25]), .i_DMA_ERR(req[34:30]),
      .i_LEVEL_WE(lvl_we), .i_LEVEL_IDX(lvl_idx), .i_LEVEL_WDATA(lvl_wdata),
      .i_LEVEL_RIDX(lvl_ridx), .i_DMA_CNT_SIZE(cnt_size), .i_DMA_CNT_ACCESS(cnt_acc),
      .o_LEVEL_RDATA(lvl_rdata), .o_VEC_VALID(vec_valid), .o_VEC_NUM(vec_num),
      .o_VEC_LEVEL(vec_level), .o_VEC_ADDR(vec_addr), .o_DMA_CNT_BYTE_ERR(byte_err));
   vector_core_model core (.i_clk(I_CLK_SYS), .i_go(acc_go), .i_size(acc_size),
      .o_access(cnt_acc), .o_size(cnt_size));
   // ----------------------------------------
   // Expected values
   // ----------------------------------------
   function automatic logic [7:0] vec_of(int k);
      if (k == 0) return 8'h01;
      if (k <= 17) return 8'(k + 6);
      if (k == 18) return 8'h16;
      if (k <= 24) return 8'(k + 5);
      return ((k - 25) % 5 < 2) ? 8'(30 + (k - 25) % 5) : 8'h20;
   endfunction
   // Sources without a level register carry the no-level code, except NMI at its fixed level
   function automatic logic [44:0] exp_of(logic [7:0] v);
      logic [4:0] l;
      l = (v >= 8'h10) ? lvl[v - 8'h10] : vector_map_pkg::LEVEL_NONE;
      if (v == 8'h0f) l = vector_map_pkg::NMI_LEVEL;
      return {v, l, base + 32'h3fc - {22'h0, v, 2'b00}};
   endfunction
   task automatic check(string name, logic [44:0] seen, logic [44:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic test_done();
      if (err_count == 0 && compares > 0 && expq.size() == 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Hold the index a few cycles so the read latency settles either way
   task automatic read_all();
      for (int i = 0; i < 18; i++) begin
         @(negedge I_CLK_SYS);
         lvl_ridx = 5'(i);
         repeat (3) @(negedge I_CLK_SYS);
         check("level read", lvl_rdata, (i < 17) ? lvl[i] : 5'h00);
      end
   endtask
   task automatic fire(logic [34:0] r, logic [7:0] v);
      @(negedge I_CLK_SYS);
      req = r;
      expq.push_back(exp_of(v));
   endtask
   // ----------------------------------------
   // Clock, watchdog, result monitor
   // ----------------------------------------
   initial begin
      I_CLK_SYS = 1'b0;
      forever #5 I_CLK_SYS = ~I_CLK_SYS;
   end
   initial begin
      #200000;
      err_count++;
      test_done();
   end
   // Oldest note pairs with each presented vector
   always @(negedge I_CLK_SYS) begin
      if (vec_valid === 1'b1) begin
         check("vector", {vec_num, vec_level, vec_addr},
            (expq.size() > 0) ? expq.pop_front() : {45{1'bx}});
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(11));
      {I_RST_B, base_we, lvl_we, acc_go, acc_size, req, lvl_idx, lvl_wdata, lvl_ridx} = '0;
      base = vector_map_pkg::TABLE_BASE_RESET;
      foreach (lvl[i]) lvl[i] = vector_map_pkg::LEVEL_RESET;
      repeat (5) @(posedge I_CLK_SYS);
      expq.push_back(exp_of(8'h00));
      @(negedge I_CLK_SYS);
      I_RST_B = 1'b1;
      read_all();
      // Levels kept below 31 so no source is ever masked
      for (int i = 0; i < 18; i++) begin
         @(negedge I_CLK_SYS);
         {lvl_we, lvl_idx, lvl_wdata} = {1'b1, 5'(i), 5'($urandom_range(30))};
         if (i < 17) lvl[i] = lvl_wdata;
      end
      @(negedge I_CLK_SYS);
      lvl_we = 1'b0;
      read_all();
      for (int k = 0; k < 35; k++) fire(35'h1 << k, vec_of(k));
      @(negedge I_CLK_SYS);
      req = '0;
      base = $urandom() & 32'hfffffc00;
      base_we = 1'b1;
      @(negedge I_CLK_SYS);
      base_we = 1'b0;
      // Single random sources against the relocated table base
      for (int j = 0; j < 30; j++) begin
         int a;
         a = $urandom_range(34);
         fire(35'h1 << a, vec_of(a));
      end
      for (int k = 0; k < 40; k++) begin
         int a;
         int b;
         a = $urandom_range(34);
         b = $urandom_range(34);
         fire((35'h1 << a) | (35'h1 << b), (vec_of(a) < vec_of(b)) ? vec_of(a) : vec_of(b));
      end
      @(negedge I_CLK_SYS);
      req = '0;
      // Second reset mid-run: base and levels must fall back to defaults
      @(negedge I_CLK_SYS);
      I_RST_B = 1'b0;
      repeat (2) @(negedge I_CLK_SYS);
      base = vector_map_pkg::TABLE_BASE_RESET;
      foreach (lvl[i]) lvl[i] = vector_map_pkg::LEVEL_RESET;
      expq.push_back(exp_of(8'h00));
      I_RST_B = 1'b1;
      read_all();
      for (int s = 0; s < 3; s++) begin
         @(negedge I_CLK_SYS);
         acc_go <= 1'b1;
         acc_size <= 2'(s);
         @(negedge I_CLK_SYS);
         acc_go <= 1'b0;
         @(negedge I_CLK_SYS);
         check("byte error", {44'h0, byte_err}, {44'h0, s == 0});
      end
      repeat (3) @(negedge I_CLK_SYS);
      test_done();
   end
endmodule

// File: dv/vector_core_model.sv
`timescale 1ns/1ps
module vector_core_model (
   input wire logic i_clk,
   input wire logic i_go,
   input wire logic [1:0] i_size,
   output logic o_access,
   output logic [1:0] o_size
);
   initial begin
      o_access = 1'b0;
      o_size = 2'h1;
   end
   // Plain single accesses only, so no write-only bit is ever read back
   always @(negedge i_clk) begin
      o_access <= i_go;
      o_size <= i_go ? i_size : ~o_size;
   end
endmodule

// File: rtl/interrupt_vector_map.sv
`timescale 1ns/1ps
// Operation
// - Mode vector is 1, no level
// - Vectors 2 to 6 system reserved
// - Coprocessor traps 7, 8; trap insn 9
// - Breaks, trace, tool NMI, undefined: 10-14
// - NMI vector 15, level fixed 15
// - External inputs 0-7 to vectors 16-23
// - External 6 and wake-up share 22
// - Reload timers 0-2 to vectors 24-26
// - Serial channel events to 27, 28
// - Dead-time trip to vector 29
// - DMA 0 and 1 to 30, 31
// - DMA 2, 3, 4 share vector 32
// - Unassigned level reads are undefined
// - Transfer count needs halfword or word
module interrupt_vector_map #(
   parameter int NUM_EXT = 8,
   parameter int NUM_RELOAD = 3
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RST_B,
   input wire logic [31:0] i_TABLE_BASE,
   input wire logic i_TABLE_BASE_WE,
   input wire logic i_MODE_REQ,
   input wire logic i_COPRO_ABSENT,
   input wire logic i_COPRO_ERROR,
   input wire logic i_EMU_TRAP,
   input wire logic i_INSN_BREAK,
   input wire logic i_OPND_BREAK,
   input wire logic i_STEP_TRACE,
   input wire logic i_TOOL_NMI,
   input wire logic i_UNDEF_INSN,
   input wire logic i_NMI,
   input wire logic [NUM_EXT-1:0] i_EXT_IRQ,
   input wire logic i_WAKEUP,
   input wire logic [NUM_RELOAD-1:0] i_RELOAD_IRQ,
   input wire logic i_SERIAL_RX,
   input wire logic i_SERIAL_TX,
   input wire logic i_DEAD_TIME_TRIP,
   input wire logic [4:0] i_DMA_END,
   input wire logic [4:0] i_DMA_ERR,
   input wire logic i_LEVEL_WE,
   input wire logic [4:0] i_LEVEL_IDX,
   input wire logic [4:0] i_LEVEL_WDATA,
   input wire logic [4:0] i_LEVEL_RIDX,
   input wire logic [1:0] i_DMA_CNT_SIZE,
   input wire logic i_DMA_CNT_ACCESS,
   output logic [4:0] o_LEVEL_RDATA,
   output logic o_VEC_VALID,
   output logic [7:0] o_VEC_NUM,
   output logic [4:0] o_VEC_LEVEL,
   output logic [31:0] o_VEC_ADDR,
   output logic o_DMA_CNT_BYTE_ERR
);

   // ----------------------------------------
   // Table base and level storage
   // ----------------------------------------
   logic [31:0] table_base_reg;
   logic [4:0] lvl_rd_idx;
   logic [4:0] lvl_rd_data;
   logic [4:0] lvl_at_idx;

   // Base held here so the core can relocate the table at will
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         table_base_reg <= vector_map_pkg::TABLE_BASE_RESET;
      end else if (i_TABLE_BASE_WE) begin
         table_base_reg <= i_TABLE_BASE;
      end
   end

   // Software-facing read port; vectoring reads the shadow copy, not this memory
   level_mem #(
      .DEPTH(vector_map_pkg::NUM_LEVEL_REGS),
      .AW(5),
      .DW(5)
   ) u_level_mem (
      .i_clk(I_CLK_SYS),
      .i_rst_b(I_RST_B),
      .i_we(i_LEVEL_WE),
      .i_waddr(i_LEVEL_IDX),
      .i_wdata(i_LEVEL_WDATA),
      .i_raddr(lvl_rd_idx),
      .o_rdata(lvl_rd_data)
   );

   // Small shadow copy gives same-cycle level lookup for the winner
   logic [4:0] lvl_shadow_reg [vector_map_pkg::NUM_LEVEL_REGS];
   genvar gl;
   generate
      for (gl = 0; gl < vector_map_pkg::NUM_LEVEL_REGS; gl++) begin : g_shadow
         always_ff @(posedge I_CLK_SYS) begin
            if (!I_RST_B) begin
               lvl_shadow_reg[gl] <= vector_map_pkg::LEVEL_RESET;
            end else if (i_LEVEL_WE && (i_LEVEL_IDX == 5'(gl))) begin
               lvl_shadow_reg[gl] <= i_LEVEL_WDATA;
            end
         end
      end
   endgenerate

   assign lvl_rd_idx = i_LEVEL_RIDX;

   // Out-of-range indices read zero; software must not rely on it
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         o_LEVEL_RDATA <= '0;
      end else begin
         o_LEVEL_RDATA <= lvl_rd_data;
      end
   end

   // ----------------------------------------
   // Source to vector selection
   // ----------------------------------------
   logic any_req;
   logic [7:0] vec_sel;
   logic [4:0] lvl_idx_sel;
   logic lvl_fixed;
   logic [4:0] lvl_fixed_val;

   // Lowest vector number wins; no source ever maps to 2..6
   always_comb begin
      any_req = 1'b1;
      vec_sel = vector_map_pkg::VEC_RESET;
      lvl_idx_sel = '0;
      lvl_fixed = 1'b1;
      lvl_fixed_val = vector_map_pkg::LEVEL_NONE;
      if (i_MODE_REQ) begin
         vec_sel = vector_map_pkg::VEC_MODE;
      end else if (i_COPRO_ABSENT) begin
         vec_sel = vector_map_pkg::VEC_COPRO_ABSENT;
      end else if (i_COPRO_ERROR) begin
         vec_sel = vector_map_pkg::VEC_COPRO_ERROR;
      end else if (i_EMU_TRAP) begin
         vec_sel = vector_map_pkg::VEC_EMU_TRAP;
      end else if (i_INSN_BREAK) begin
         vec_sel = vector_map_pkg::VEC_INSN_BREAK;
      end else if (i_OPND_BREAK) begin
         vec_sel = vector_map_pkg::VEC_OPND_BREAK;
      end else if (i_STEP_TRACE) begin
         vec_sel = vector_map_pkg::VEC_STEP_TRACE;
      end else if (i_TOOL_NMI) begin
         vec_sel = vector_map_pkg::VEC_TOOL_NMI;
      end else if (i_UNDEF_INSN) begin
         vec_sel = vector_map_pkg::VEC_UNDEF_INSN;
      end else if (i_NMI) begin
         vec_sel = vector_map_pkg::VEC_NMI;
         lvl_fixed_val = vector_map_pkg::NMI_LEVEL;
      end else if (|i_EXT_IRQ || i_WAKEUP) begin
         lvl_fixed = 1'b0;
         for (int k = NUM_EXT - 1; k >= 0; k--) begin
            // Wake-up folds into input 6
            if (i_EXT_IRQ[k] || (k == 6 && i_WAKEUP)) begin
               vec_sel = vector_map_pkg::VEC_EXT_BASE + 8'(k);
               lvl_idx_sel = vector_map_pkg::LVL_EXT_BASE + 5'(k);
            end
         end
      end else if (|i_RELOAD_IRQ) begin
         lvl_fixed = 1'b0;
         for (int k = NUM_RELOAD - 1; k >= 0; k--) begin
            if (i_RELOAD_IRQ[k]) begin
               vec_sel = vector_map_pkg::VEC_RELOAD_BASE + 8'(k);
               lvl_idx_sel = vector_map_pkg::LVL_RELOAD_BASE + 5'(k);
            end
         end
      end else if (i_SERIAL_RX) begin
         lvl_fixed = 1'b0;
         vec_sel = vector_map_pkg::VEC_SERIAL_RX;
         lvl_idx_sel = vector_map_pkg::LVL_SERIAL_RX;
      end else if (i_SERIAL_TX) begin
         lvl_fixed = 1'b0;
         vec_sel = vector_map_pkg::VEC_SERIAL_TX;
         lvl_idx_sel = vector_map_pkg::LVL_SERIAL_TX;
      end else if (i_DEAD_TIME_TRIP) begin
         lvl_fixed = 1'b0;
         vec_sel = vector_map_pkg::VEC_DEAD_TIME;
         lvl_idx_sel = vector_map_pkg::LVL_DEAD_TIME;
      end else if (i_DMA_END[0] || i_DMA_ERR[0]) begin
         lvl_fixed = 1'b0;
         vec_sel = vector_map_pkg::VEC_DMA0;
         lvl_idx_sel = vector_map_pkg::LVL_DMA0;
      end else if (i_DMA_END[1] || i_DMA_ERR[1]) begin
         lvl_fixed = 1'b0;
         vec_sel = vector_map_pkg::VEC_DMA1;
         lvl_idx_sel = vector_map_pkg::LVL_DMA1;
      end else if (|i_DMA_END[4:2] || |i_DMA_ERR[4:2]) begin
         lvl_fixed = 1'b0;
         vec_sel = vector_map_pkg::VEC_DMA234;
         lvl_idx_sel = vector_map_pkg::LVL_DMA234;
      end else begin
         any_req = 1'b0;
      end
   end

   assign lvl_at_idx = lvl_shadow_reg[lvl_idx_sel];

   // ----------------------------------------
   // Vector output
   // ----------------------------------------
   logic in_reset_reg;

   // First cycle after reset presents the reset vector
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         in_reset_reg <= 1'b1;
      end else begin
         in_reset_reg <= 1'b0;
      end
   end

   // Address counts down from the top word of the table
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         o_VEC_VALID <= 1'b0;
         o_VEC_NUM <= vector_map_pkg::VEC_RESET;
         o_VEC_LEVEL <= vector_map_pkg::LEVEL_NONE;
         o_VEC_ADDR <= vector_map_pkg::TABLE_BASE_RESET + 32'(vector_map_pkg::OFFSET_TOP);
      end else if (in_reset_reg) begin
         o_VEC_VALID <= 1'b1;
         o_VEC_NUM <= vector_map_pkg::VEC_RESET;
         o_VEC_LEVEL <= vector_map_pkg::LEVEL_NONE;
         o_VEC_ADDR <= table_base_reg + 32'(vector_map_pkg::OFFSET_TOP);
      end else begin
         o_VEC_VALID <= any_req;
         o_VEC_NUM <= vec_sel;
         o_VEC_LEVEL <= lvl_fixed ? lvl_fixed_val : lvl_at_idx;
         o_VEC_ADDR <= table_base_reg + 32'(vector_map_pkg::OFFSET_TOP)
            - {22'h0, vec_sel, 2'b00};
      end
   end

   // ----------------------------------------
   // Transfer count access guard
   // ----------------------------------------
   // Flags byte-wide access (size 0) so the bus can refuse it
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         o_DMA_CNT_BYTE_ERR <= 1'b0;
      end else begin
         o_DMA_CNT_BYTE_ERR <= i_DMA_CNT_ACCESS && (i_DMA_CNT_SIZE == 2'h0);
      end
   end

endmodule

// File: rtl/level_mem.sv
`timescale 1ns/1ps
module level_mem #(
   parameter int DEPTH = 17,
   parameter int AW = 5,
   parameter int DW = 5
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [DW-1:0] i_wdata,
   input wire logic [AW-1:0] i_raddr,
   output logic [DW-1:0] o_rdata
);

   logic [DW-1:0] mem_reg [DEPTH];

   // ----------------------------------------
   // Storage, one entry per level register
   // ----------------------------------------
   // Every entry resets so a level is never unknown after reset
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_ent
         always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
               mem_reg[gi] <= DW'(vector_map_pkg::LEVEL_RESET);
            end else if (i_we && (i_waddr == AW'(gi))) begin
               mem_reg[gi] <= i_wdata;
            end
         end
      end
   endgenerate

   // Registered read port
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_rdata <= '0;
      end else if (i_raddr < AW'(DEPTH)) begin
         o_rdata <= mem_reg[i_raddr];
      end else begin
         o_rdata <= '0;
      end
   end

endmodule

// File: rtl/vector_map_pkg.sv
package vector_map_pkg;

   // ----------------------------------------
   // Vector numbers
   // ----------------------------------------
   localparam logic [7:0] VEC_RESET = 8'h00;
   localparam logic [7:0] VEC_MODE = 8'h01;
   localparam logic [7:0] VEC_SYS_FIRST = 8'h02;
   localparam logic [7:0] VEC_SYS_LAST = 8'h06;
   localparam logic [7:0] VEC_COPRO_ABSENT = 8'h07;
   localparam logic [7:0] VEC_COPRO_ERROR = 8'h08;
   localparam logic [7:0] VEC_EMU_TRAP = 8'h09;
   localparam logic [7:0] VEC_INSN_BREAK = 8'h0a;
   localparam logic [7:0] VEC_OPND_BREAK = 8'h0b;
   localparam logic [7:0] VEC_STEP_TRACE = 8'h0c;
   localparam logic [7:0] VEC_TOOL_NMI = 8'h0d;
   localparam logic [7:0] VEC_UNDEF_INSN = 8'h0e;
   localparam logic [7:0] VEC_NMI = 8'h0f;
   localparam logic [7:0] VEC_EXT_BASE = 8'h10;
   localparam logic [7:0] VEC_RELOAD_BASE = 8'h18;
   localparam logic [7:0] VEC_SERIAL_RX = 8'h1b;
   localparam logic [7:0] VEC_SERIAL_TX = 8'h1c;
   localparam logic [7:0] VEC_DEAD_TIME = 8'h1d;
   localparam logic [7:0] VEC_DMA0 = 8'h1e;
   localparam logic [7:0] VEC_DMA1 = 8'h1f;
   localparam logic [7:0] VEC_DMA234 = 8'h20;

   // ----------------------------------------
   // Level register indices and levels
   // ----------------------------------------
   localparam logic [4:0] LVL_EXT_BASE = 5'h00;
   localparam logic [4:0] LVL_RELOAD_BASE = 5'h08;
   localparam logic [4:0] LVL_SERIAL_RX = 5'h0b;
   localparam logic [4:0] LVL_SERIAL_TX = 5'h0c;
   localparam logic [4:0] LVL_DEAD_TIME = 5'h0d;
   localparam logic [4:0] LVL_DMA0 = 5'h0e;
   localparam logic [4:0] LVL_DMA1 = 5'h0f;
   localparam logic [4:0] LVL_DMA234 = 5'h10;
   localparam int NUM_LEVEL_REGS = 17;
   localparam logic [4:0] NMI_LEVEL = 5'h0f;
   localparam logic [4:0] LEVEL_RESET = 5'h1f;
   localparam logic [4:0] LEVEL_NONE = 5'h1f;

   // ----------------------------------------
   // Vector address forming
   // ----------------------------------------
   localparam logic [31:0] TABLE_BASE_RESET = 32'h000ffc00;
   localparam logic [9:0] OFFSET_TOP = 10'h3fc;

endpackage
